// ==== core/clb_cfg.svh ====
// Constants shared by both ends of the local bus cycle signalling.
`ifndef CLB_CFG_SVH
`define CLB_CFG_SVH
`define CLB_ADDR_W 25
`define CLB_DATA_W 16
`define CLB_A20_BIT 19
`define CLB_BE_NONE 2'h3
`define CLB_BE_BOTH 2'h0
`define CLB_BE_HI 1
`define CLB_BE_LO 0
`define CLB_BYTE_W 8
`define CLB_ADDR_RST 25'h000_0000
`define CLB_DATA_RST 16'h0000
`define CLB_HOST_WAIT 3'h2
`define CLB_WAIT_RST 3'h0
`define CLB_WAIT_ONE 3'h1
`define CLB_READY_HOLD 2'h2
`define CLB_HOLD_RST 2'h0
`define CLB_HOLD_ONE 2'h1
`define CLB_HOST_DEPTH 16
`define CLB_HOST_IDX_W 4
`define CLB_INTA_VECTOR 16'h0020
`define CLB_IO_READ_VALUE 16'h00ff
`endif

// ==== core/clb_pkg.sv ====
// Types shared by both ends of the local bus cycle signalling.
`default_nettype none
package clb_pkg;
  typedef enum logic [1:0] {
    CLB_D_IDLE,
    CLB_D_T1,
    CLB_D_T2
  } clb_dev_state_t;
  typedef enum logic [1:0] {
    CLB_H_IDLE,
    CLB_H_WAIT,
    CLB_H_READY
  } clb_host_state_t;
  typedef logic [24:0] clb_addr_t;
  typedef logic [15:0] clb_data_t;
endpackage
`default_nettype wire

// ==== core/clb_bus_if.sv ====
// Local bus pins joining the processor end and the system logic end.
`timescale 1ns/1ns
`default_nettype none
interface clb_bus_if;
  import clb_pkg::*;
  clb_addr_t word_address_out;
  logic      cycle_valid_strobe_n;
  logic      upper_byte_enable_n;
  logic      lower_byte_enable_n;
  logic      write_not_read;
  logic      data_not_control;
  logic      memory_not_io;
  logic      bus_out_oe_n;
  clb_data_t data_lines_dev_o;
  logic      data_lines_dev_oe_n;
  clb_data_t data_lines_host_o;
  logic      data_lines_host_oe_n;
  clb_data_t data_lines;
  logic      ready_n;
  logic      addr_bit20_mask_n;
  logic      copro_busy_n;
  logic      bus_float_n;

  // Resolved level of the shared data lines; an undriven bus reads zero.
  assign data_lines = !data_lines_dev_oe_n  ? data_lines_dev_o  :
                      !data_lines_host_oe_n ? data_lines_host_o : '0;

  modport dev (
    output word_address_out, cycle_valid_strobe_n, upper_byte_enable_n,
    output lower_byte_enable_n, write_not_read, data_not_control,
    output memory_not_io, bus_out_oe_n, data_lines_dev_o, data_lines_dev_oe_n,
    input  data_lines, ready_n, addr_bit20_mask_n, copro_busy_n, bus_float_n
  );
  modport host (
    input  word_address_out, cycle_valid_strobe_n, upper_byte_enable_n,
    input  lower_byte_enable_n, write_not_read, data_not_control,
    input  memory_not_io, bus_out_oe_n, data_lines,
    output data_lines_host_o, data_lines_host_oe_n, ready_n,
    output addr_bit20_mask_n, copro_busy_n, bus_float_n
  );
endinterface
`default_nettype wire

// ==== core/clb_host_end.sv ====
// System logic end: answers memory data cycles from a small word memory, other reads with fixed values.
`timescale 1ns/1ns
`default_nettype none
`include "clb_cfg.svh"
module clb_host_end (
  input  wire logic      clk_sys,
  input  wire logic      resetn,
  clb_bus_if.host        bus,
  input  wire logic      mask_req_n,
  input  wire logic      copro_busy_req,
  input  wire logic      float_req,
  output logic           obs_valid,
  output clb_pkg::clb_addr_t obs_addr,
  output logic           obs_write,
  output logic           obs_mem,
  output logic           obs_data_cyc,
  output clb_pkg::clb_data_t obs_data
);
  import clb_pkg::*;

  clb_host_state_t st_r, st_nxt;
  logic [2:0] wait_r, wait_nxt;
  logic [1:0] hold_r, hold_nxt;
  clb_addr_t  addr_r, addr_nxt;
  logic [1:0] be_n_r, be_n_nxt;
  logic       wr_r, wr_nxt, mem_r, mem_nxt, dc_r, dc_nxt;
  logic       rdy_n_r, rdy_n_nxt, doe_n_r, doe_n_nxt, obs_v_nxt;
  clb_data_t  dout_r, dout_nxt, obs_d_nxt;
  clb_data_t  mem_a [`CLB_HOST_DEPTH];
  logic [`CLB_HOST_IDX_W-1:0] idx;
  logic       mem_we;

  assign idx = addr_r[`CLB_HOST_IDX_W-1:0];
  // Only data writes to memory space land in the store.
  assign mem_we = (st_r == CLB_H_READY) && (hold_r == `CLB_HOLD_ONE) && wr_r && mem_r && dc_r;

  always_comb begin
    st_nxt = st_r;
    wait_nxt = wait_r;
    hold_nxt = hold_r;
    addr_nxt = addr_r;
    be_n_nxt = be_n_r;
    wr_nxt = wr_r;
    mem_nxt = mem_r;
    dc_nxt = dc_r;
    rdy_n_nxt = 1'b1;
    doe_n_nxt = 1'b1;
    dout_nxt = dout_r;
    obs_v_nxt = 1'b0;
    obs_d_nxt = obs_data;
    case (st_r)
      CLB_H_IDLE: begin
        // The strobe only qualifies the cycle fields while they are driven.
        if (!bus.cycle_valid_strobe_n && !bus.bus_out_oe_n) begin
          addr_nxt = bus.word_address_out;
          be_n_nxt = {bus.upper_byte_enable_n, bus.lower_byte_enable_n};
          wr_nxt = bus.write_not_read;
          mem_nxt = bus.memory_not_io;
          dc_nxt = bus.data_not_control;
          wait_nxt = `CLB_WAIT_RST;
          st_nxt = CLB_H_WAIT;
        end
      end
      CLB_H_WAIT: begin
        wait_nxt = wait_r + `CLB_WAIT_ONE;
        if (wait_r == `CLB_HOST_WAIT) begin
          st_nxt = CLB_H_READY;
          hold_nxt = `CLB_HOLD_RST;
          rdy_n_nxt = 1'b0;
          doe_n_nxt = wr_r;
          if (!dc_r) begin
            dout_nxt = `CLB_INTA_VECTOR;
          end else if (mem_r) begin
            dout_nxt = mem_a[idx];
          end else begin
            dout_nxt = `CLB_IO_READ_VALUE;
          end
        end
      end
      CLB_H_READY: begin
        hold_nxt = hold_r + `CLB_HOLD_ONE;
        // Ready stays low for a whole bus phase so the processor sees it.
        if (hold_r == `CLB_HOLD_ONE) begin
          st_nxt = CLB_H_IDLE;
          obs_v_nxt = 1'b1;
          obs_d_nxt = wr_r ? bus.data_lines : dout_r;
        end else begin
          rdy_n_nxt = 1'b0;
          doe_n_nxt = wr_r;
        end
      end
      default: st_nxt = CLB_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= CLB_H_IDLE;
      wait_r <= `CLB_WAIT_RST;
      hold_r <= `CLB_HOLD_RST;
      addr_r <= `CLB_ADDR_RST;
      be_n_r <= `CLB_BE_NONE;
      wr_r <= 1'b0;
      mem_r <= 1'b0;
      dc_r <= 1'b0;
      rdy_n_r <= 1'b1;
      doe_n_r <= 1'b1;
      dout_r <= `CLB_DATA_RST;
      obs_valid <= 1'b0;
      obs_data <= `CLB_DATA_RST;
      bus.addr_bit20_mask_n <= 1'b1;
      bus.copro_busy_n <= 1'b1;
      bus.bus_float_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
      wait_r <= wait_nxt;
      hold_r <= hold_nxt;
      addr_r <= addr_nxt;
      be_n_r <= be_n_nxt;
      wr_r <= wr_nxt;
      mem_r <= mem_nxt;
      dc_r <= dc_nxt;
      rdy_n_r <= rdy_n_nxt;
      doe_n_r <= doe_n_nxt;
      dout_r <= dout_nxt;
      obs_valid <= obs_v_nxt;
      obs_data <= obs_d_nxt;
      bus.addr_bit20_mask_n <= mask_req_n;
      bus.copro_busy_n <= !copro_busy_req;
      bus.bus_float_n <= !float_req;
    end
  end

  // Byte lanes of the store follow the two enables.
  always_ff @(posedge clk_sys) begin
    if (mem_we && !be_n_r[`CLB_BE_HI]) begin
      mem_a[idx][`CLB_DATA_W-1:`CLB_BYTE_W] <= bus.data_lines[`CLB_DATA_W-1:`CLB_BYTE_W];
    end
    if (mem_we && !be_n_r[`CLB_BE_LO]) begin
      mem_a[idx][`CLB_BYTE_W-1:0] <= bus.data_lines[`CLB_BYTE_W-1:0];
    end
  end

  assign bus.ready_n = rdy_n_r;
  assign bus.data_lines_host_oe_n = doe_n_r;
  assign bus.data_lines_host_o = dout_r;
  assign obs_addr = addr_r;
  assign obs_write = wr_r;
  assign obs_mem = mem_r;
  assign obs_data_cyc = dc_r;
endmodule
`default_nettype wire

// ==== core/clb_dev_end.sv ====
// Processor end of the local bus: cycle definition, address and data.
// What this block does
// - Mask low forces address bit 20 to zero.
// - Mask high passes true address bit 20.
// - Mask ignored while bus outputs float.
// - System keeps mask high for high management accesses.
// - Drive 25-bit word address of the cycle.
// - Strobe only with valid definition and address.
// - Upper enable low when high byte moves.
// - Lower enable low when low byte moves.
// - Data/control high for data, low control.
// - Data lines received on reads, driven on writes.
// - Coprocessor holds busy low while occupied.
// - Everything timed from the double-rate clock.
// - Memory/IO high for memory, low for I/O.
// - Write/read high for writes, low reads.
// - System asserts ready low to end cycle.
`timescale 1ns/1ns
`default_nettype none
`include "clb_cfg.svh"
module clb_dev_end (
  input  wire logic          clk_sys,
  input  wire logic          resetn,
  clb_bus_if.dev             bus,
  input  wire logic          req_valid,
  input  wire logic          req_write,
  input  wire logic          req_mem,
  input  wire logic          req_data_cyc,
  input  wire clb_pkg::clb_addr_t req_addr,
  input  wire logic [1:0]    req_be_n,
  input  wire clb_pkg::clb_data_t req_wdata,
  output logic               req_taken,
  output logic               done,
  output clb_pkg::clb_data_t rdata,
  output logic               copro_busy,
  output logic               bus_floated
);
  import clb_pkg::*;

  // The system clock stands for the double-rate clock; a toggle halves it
  // into the processor phase enable that paces every bus state.
  logic           ph_r, ph_nxt;
  logic           ph_en;
  clb_dev_state_t st_r, st_nxt;
  clb_addr_t      addr_r, addr_nxt;
  clb_addr_t      addr_masked;
  logic [1:0]     be_n_r, be_n_nxt;
  logic [1:0]     be_n_fixed;
  logic           wr_r, wr_nxt;
  logic           dc_r, dc_nxt;
  logic           mio_r, mio_nxt;
  logic           ads_n_r, ads_n_nxt;
  logic           oe_n_r, oe_n_nxt;
  clb_data_t      wdata_r, wdata_nxt;
  logic           doe_n_r, doe_n_nxt;
  logic           dlo_n_r, dlo_n_nxt;
  logic           taken_nxt;
  logic           done_nxt;
  clb_data_t      rdata_nxt;
  logic           busy_nxt;
  logic           start;

  // Phase divider.
  always_comb begin
    ph_nxt = !ph_r;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ph_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
    end
  end

  assign ph_en = ph_r;

  // Address bit 20 is gated before it ever reaches the pin register, so
  // the masked value is what the whole cycle carries.
  always_comb begin
    addr_masked = req_addr;
    if (!bus.addr_bit20_mask_n) begin
      addr_masked[`CLB_A20_BIT] = 1'b0;
    end else begin
      addr_masked[`CLB_A20_BIT] = req_addr[`CLB_A20_BIT];
    end
  end

  // A request naming no byte is widened to a full word rather than sent
  // with both enables high, which the far side would complete without storing a byte.
  always_comb begin
    if (req_be_n == `CLB_BE_NONE) begin
      be_n_fixed = `CLB_BE_BOTH;
    end else begin
      be_n_fixed = req_be_n;
    end
  end

  // A new cycle starts only on a phase edge with the outputs driven.
  assign start = ph_en && req_valid && bus.bus_float_n && (st_r == CLB_D_IDLE);

  // Bus cycle sequencer.
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    be_n_nxt = be_n_r;
    wr_nxt = wr_r;
    dc_nxt = dc_r;
    mio_nxt = mio_r;
    ads_n_nxt = ads_n_r;
    wdata_nxt = wdata_r;
    doe_n_nxt = doe_n_r;
    taken_nxt = 1'b0;
    done_nxt = 1'b0;
    rdata_nxt = rdata;
    case (st_r)
      CLB_D_IDLE: begin
        // Address and cycle fields load only here, never while floated.
        if (start) begin
          addr_nxt = addr_masked;
          be_n_nxt = be_n_fixed;
          wr_nxt = req_write;
          dc_nxt = req_data_cyc;
          mio_nxt = req_mem;
          wdata_nxt = req_wdata;
          ads_n_nxt = 1'b0;
          doe_n_nxt = !req_write;
          taken_nxt = 1'b1;
          st_nxt = CLB_D_T1;
        end
      end
      CLB_D_T1: begin
        if (ph_en) begin
          ads_n_nxt = 1'b1;
          st_nxt = CLB_D_T2;
        end
      end
      CLB_D_T2: begin
        // Ready is looked at once per phase; fields stay put until then.
        if (ph_en && !bus.ready_n) begin
          done_nxt = 1'b1;
          doe_n_nxt = 1'b1;
          if (!wr_r) begin
            rdata_nxt = bus.data_lines;
          end
          st_nxt = CLB_D_IDLE;
        end
      end
      default: begin
        ads_n_nxt = 1'b1;
        doe_n_nxt = 1'b1;
        st_nxt = CLB_D_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_r <= CLB_D_IDLE;
      addr_r <= `CLB_ADDR_RST;
      be_n_r <= `CLB_BE_NONE;
      wr_r <= 1'b0;
      dc_r <= 1'b0;
      mio_r <= 1'b0;
      ads_n_r <= 1'b1;
      wdata_r <= `CLB_DATA_RST;
      doe_n_r <= 1'b1;
      req_taken <= 1'b0;
      done <= 1'b0;
      rdata <= `CLB_DATA_RST;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      be_n_r <= be_n_nxt;
      wr_r <= wr_nxt;
      dc_r <= dc_nxt;
      mio_r <= mio_nxt;
      ads_n_r <= ads_n_nxt;
      wdata_r <= wdata_nxt;
      doe_n_r <= doe_n_nxt;
      req_taken <= taken_nxt;
      done <= done_nxt;
      rdata <= rdata_nxt;
    end
  end

  // Float and coprocessor status. A float that lands mid-cycle releases
  // the pins at once but the sequencer still waits for ready; the far
  // side must not assert float in a cycle it has not finished.
  always_comb begin
    oe_n_nxt = !bus.bus_float_n;
    busy_nxt = !bus.copro_busy_n;
    // The data drive enable gets its own flop so the pin leaves no gate
    // behind a register; it tracks the sequencer enable or the float.
    dlo_n_nxt = doe_n_nxt | oe_n_nxt;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      oe_n_r <= 1'b0;
      copro_busy <= 1'b0;
      dlo_n_r <= 1'b1;
    end else begin
      oe_n_r <= oe_n_nxt;
      copro_busy <= busy_nxt;
      dlo_n_r <= dlo_n_nxt;
    end
  end

  assign bus_floated = oe_n_r;

  // Pin drive. The data lines are released whenever the pins float.
  assign bus.word_address_out = addr_r;
  assign bus.cycle_valid_strobe_n = ads_n_r;
  assign bus.upper_byte_enable_n = be_n_r[`CLB_BE_HI];
  assign bus.lower_byte_enable_n = be_n_r[`CLB_BE_LO];
  assign bus.write_not_read = wr_r;
  assign bus.data_not_control = dc_r;
  assign bus.memory_not_io = mio_r;
  assign bus.bus_out_oe_n = oe_n_r;
  assign bus.data_lines_dev_o = wdata_r;
  assign bus.data_lines_dev_oe_n = dlo_n_r;
endmodule
`default_nettype wire

// ==== tb/clb_bus_chk.sv ====
// Concurrent checks on the local bus pins between the two ends.
`timescale 1ns/1ns
`default_nettype none
`include "clb_cfg.svh"
module clb_bus_chk (
  input wire logic               clk_sys,
  input wire logic               resetn,
  input wire clb_pkg::clb_addr_t word_address_out,
  input wire logic               cycle_valid_strobe_n,
  input wire logic               upper_byte_enable_n,
  input wire logic               lower_byte_enable_n,
  input wire logic               write_not_read,
  input wire logic               data_not_control,
  input wire logic               memory_not_io,
  input wire logic               bus_out_oe_n,
  input wire logic               data_lines_dev_oe_n,
  input wire logic               data_lines_host_oe_n,
  input wire logic               ready_n,
  input wire logic               addr_bit20_mask_n
);
  import clb_pkg::*;
  logic [29:0] defn;
  assign defn = {word_address_out, upper_byte_enable_n, lower_byte_enable_n,
                 write_not_read, data_not_control, memory_not_io};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  chk_strobe_width: assert property (
    $fell(cycle_valid_strobe_n) |=> !cycle_valid_strobe_n ##1 cycle_valid_strobe_n)
    else $error("Strobe not low for two clocks.");
  chk_enable_some: assert property (
    !cycle_valid_strobe_n |-> !(upper_byte_enable_n && lower_byte_enable_n))
    else $error("Cycle started with no byte enabled.");
  chk_defn_stable: assert property (
    $fell(cycle_valid_strobe_n) |=> $stable(defn) [*5])
    else $error("Cycle definition moved before ready.");
  chk_ready_delay: assert property (
    $fell(cycle_valid_strobe_n) |-> ##4 $fell(ready_n))
    else $error("Ready not at the expected clock.");
  chk_ready_width: assert property (
    $fell(ready_n) |=> !ready_n ##1 ready_n)
    else $error("Ready not low for two clocks.");
  chk_dir_by_type: assert property (
    !cycle_valid_strobe_n |-> data_lines_dev_oe_n == !write_not_read)
    else $error("Data direction does not match cycle type.");
  chk_no_fight: assert property (
    data_lines_dev_oe_n || data_lines_host_oe_n)
    else $error("Both ends drive the data lines.");
  chk_read_answer: assert property (
    $fell(ready_n) && !write_not_read |-> (!data_lines_host_oe_n) [*2])
    else $error("Read data not driven with ready.");
  chk_mask_clears: assert property (
    $fell(cycle_valid_strobe_n) && !$past(addr_bit20_mask_n)
      |-> !word_address_out[`CLB_A20_BIT])
    else $error("Masked address bit 20 not zero.");
  chk_float_hold: assert property (
    bus_out_oe_n |-> $stable(word_address_out) && cycle_valid_strobe_n)
    else $error("Address or strobe moved while floated.");
  cover property ($fell(cycle_valid_strobe_n) && write_not_read);
  cover property ($fell(cycle_valid_strobe_n) && !write_not_read);
  cover property ($fell(cycle_valid_strobe_n) && !$past(addr_bit20_mask_n));
  cover property ($rose(bus_out_oe_n));
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench joining both ends of the local bus.
`timescale 1ns/1ns
`default_nettype none
`include "clb_cfg.svh"
module testbench;
  import clb_pkg::*;
  logic      clk_sys = 1'b0;
  logic      resetn;
  logic      req_valid;
  logic      req_write;
  logic      req_mem;
  logic      req_data_cyc;
  clb_addr_t req_addr;
  logic [1:0] req_be_n;
  clb_data_t req_wdata;
  logic      req_taken;
  logic      done;
  clb_data_t rdata;
  logic      copro_busy;
  logic      bus_floated;
  logic      mask_req_n;
  logic      copro_busy_req;
  logic      float_req;
  logic      obs_valid;
  clb_addr_t obs_addr;
  logic      obs_write;
  logic      obs_mem;
  logic      obs_data_cyc;
  clb_data_t obs_data;
  int        n_mismatch = 0;
  int        n_checks = 0;

  always #4 clk_sys = ~clk_sys;

  clb_bus_if bus ();
  clb_dev_end i_clb_dev_end (.clk_sys, .resetn, .bus(bus), .req_valid, .req_write,
    .req_mem, .req_data_cyc, .req_addr, .req_be_n, .req_wdata, .req_taken, .done,
    .rdata, .copro_busy, .bus_floated);
  clb_host_end i_clb_host_end (.clk_sys, .resetn, .bus(bus), .mask_req_n,
    .copro_busy_req, .float_req, .obs_valid, .obs_addr, .obs_write, .obs_mem,
    .obs_data_cyc, .obs_data);
  clb_bus_chk i_clb_bus_chk (.clk_sys, .resetn,
    .word_address_out(bus.word_address_out),
    .cycle_valid_strobe_n(bus.cycle_valid_strobe_n),
    .upper_byte_enable_n(bus.upper_byte_enable_n),
    .lower_byte_enable_n(bus.lower_byte_enable_n),
    .write_not_read(bus.write_not_read), .data_not_control(bus.data_not_control),
    .memory_not_io(bus.memory_not_io), .bus_out_oe_n(bus.bus_out_oe_n),
    .data_lines_dev_oe_n(bus.data_lines_dev_oe_n),
    .data_lines_host_oe_n(bus.data_lines_host_oe_n), .ready_n(bus.ready_n),
    .addr_bit20_mask_n(bus.addr_bit20_mask_n));

  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One whole cycle; expectations come from the request and the mask level.
  task automatic bus_cycle(input logic w, input logic m, input logic dc, input clb_addr_t a,
                           input logic [1:0] be, input clb_data_t wd, input clb_data_t ex);
    clb_addr_t  ea;
    logic [1:0] ebe;
    int         k;
    ea = a;
    if (!mask_req_n) ea[`CLB_A20_BIT] = 1'b0;
    ebe = (be == `CLB_BE_NONE) ? `CLB_BE_BOTH : be;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= w;
    req_mem <= m;
    req_data_cyc <= dc;
    req_addr <= a;
    req_be_n <= be;
    req_wdata <= wd;
    k = 0;
    do begin @(posedge clk_sys); #1; k++; end while (req_taken !== 1'b1 && k < 50);
    cmp({17'h0, req_taken, bus.word_address_out,
         bus.upper_byte_enable_n, bus.lower_byte_enable_n, bus.write_not_read,
         bus.data_not_control, bus.memory_not_io}, {17'h0, 1'b1, ea, ebe, w, dc, m});
    if (w) cmp({32'h0, bus.data_lines}, {32'h0, wd});
    @(posedge clk_sys);
    req_valid <= 1'b0;
    k = 0;
    do begin @(posedge clk_sys); #1; k++; end while (done !== 1'b1 && k < 50);
    if (!w) cmp({32'h0, rdata}, {32'h0, ex});
    cmp({2'h0, obs_valid, done, obs_addr, obs_write, obs_mem, obs_data_cyc,
         obs_data}, {2'h0, 2'h3, ea, w, m, dc, w ? wd : ex});
  endtask

  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_mem = 1'b0;
    req_data_cyc = 1'b0;
    req_addr = '0;
    req_be_n = 2'h0;
    req_wdata = '0;
    mask_req_n = 1'b1;
    copro_busy_req = 1'b0;
    float_req = 1'b0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    bus_cycle(1, 1, 1, 25'h012_3455, 2'h0, 16'ha5c3, 16'h0000);
    bus_cycle(0, 1, 1, 25'h012_3455, 2'h0, 16'h0000, 16'ha5c3);
    bus_cycle(0, 0, 1, 25'h000_0060, 2'h0, 16'h0000, `CLB_IO_READ_VALUE);
    bus_cycle(0, 1, 0, 25'h07f_fff8, 2'h0, 16'h0000, `CLB_INTA_VECTOR);
    bus_cycle(1, 0, 1, 25'h000_0061, 2'h2, 16'h005a, 16'h0000);
    bus_cycle(1, 1, 1, 25'h1ff_ffff, 2'h1, 16'h3c00, 16'h0000);
    bus_cycle(1, 1, 1, 25'h000_0002, 2'h3, 16'h1234, 16'h0000);
    @(posedge clk_sys);
    mask_req_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    bus_cycle(1, 1, 1, 25'h008_0004, 2'h0, 16'hbeef, 16'h0000);
    @(posedge clk_sys);
    mask_req_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    bus_cycle(0, 1, 1, 25'h008_0004, 2'h0, 16'h0000, 16'hbeef);
    // Mask toggles and a request waits while floated; nothing may load.
    @(posedge clk_sys);
    float_req <= 1'b1;
    mask_req_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    req_valid <= 1'b1;
    req_addr <= 25'h008_0006;
    repeat (2) @(posedge clk_sys);
    #1;
    cmp({20'h0, bus_floated, bus.bus_out_oe_n, bus.cycle_valid_strobe_n,
         bus.word_address_out}, {20'h0, 3'h7, 25'h008_0004});
    @(posedge clk_sys);
    req_valid <= 1'b0;
    float_req <= 1'b0;
    mask_req_n <= 1'b1;
    copro_busy_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp({46'h0, copro_busy, bus.bus_out_oe_n}, {46'h0, 1'b1, 1'b0});
    @(posedge clk_sys);
    copro_busy_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp({47'h0, copro_busy}, 48'h0);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire
